// ===== sac_top.sv
`timescale 1ns/100ps
module sac_top #(
    parameter int RES_BITS    = sac_pkg::RES_DEFAULT,
    parameter int ID_WAIT_CYC = sac_pkg::ID_WAIT_CYC
) (
    // clock and reset
    input  wire logic                                           clk,
    input  wire logic                                           srst,
    // host bus
    input  wire sac_pkg::sac_req_s                              req,
    output logic [7:0]                                          rdata,
    output logic                                                ack,
    // shared open-drain trigger
    input  wire logic                                           trig_n_in,
    output logic                                                trig_n_out,
    output logic                                                trig_oe,
    // converters
    output logic                                                conv_start,
    input  wire logic [sac_pkg::NUM_CH-1:0]                     adc_busy,
    input  wire logic [sac_pkg::NUM_CH-1:0][RES_BITS-1:0]       adc_raw,
    // serial eeprom
    output logic                                                ee_cs,
    output logic                                                ee_sclk,
    input  wire logic                                           ee_do,
    // status
    output logic                                                id_ready
);
    import sac_pkg::*;

    localparam int LSH = SAMPLE_W - RES_BITS;
    localparam logic [SAMPLE_W-1:0] LOW_MASK = SAMPLE_W'((1 << LSH) - 1);
    localparam int WAIT_W = $clog2(ID_WAIT_CYC + 1);
    localparam int DIV_W  = $clog2(EE_DIV);

    ////////////////////////////////////////////////////////////////////////////////
    // synchronisers: only stage two is read
    logic [1:0]                           trig_sync;
    logic                                 trig_prev;
    logic [NUM_CH-1:0]                    busy_m, busy_s;
    logic [NUM_CH-1:0][RES_BITS-1:0]      raw_m, raw_s;
    logic                                 ee_m, ee_s;

    always_ff @(posedge clk) begin
        if (srst) begin
            trig_sync <= 2'b11;
            trig_prev <= 1'b1;
        end else begin
            trig_sync <= {trig_sync[0], trig_n_in};
            trig_prev <= trig_sync[1];
        end
    end

    always_ff @(posedge clk) begin
        busy_m <= adc_busy;
        busy_s <= busy_m;
        raw_m  <= adc_raw;
        raw_s  <= raw_m;
        ee_m   <= ee_do;
        ee_s   <= ee_m;
    end

    wire trig_fall = trig_prev & ~trig_sync[1];
    wire any_busy  = |busy_s;

    ////////////////////////////////////////////////////////////////////////////////
    // host decode and wait states
    logic ws_done;
    wire io_rd     = req.io_sel & ~req.wr;
    wire data_rd   = io_rd & req.addr[0] & (req.addr <= ADDR_DATA_LAST);
    wire conv_wr   = req.io_sel & req.wr & (req.addr == ADDR_CONVERT);
    wire stat_rd   = io_rd & (req.addr == ADDR_STATUS);

    always_ff @(posedge clk) begin
        if (srst) ws_done <= 1'b0;
        else      ws_done <= data_rd & ~ws_done;
    end

    assign ack = (req.io_sel | req.id_sel) & (~data_rd | ws_done);

    ////////////////////////////////////////////////////////////////////////////////
    // trigger drive; the guard hides our own pulse coming back through the pin
    logic [3:0] trig_cnt;
    assign trig_n_out = 1'b0;

    always_ff @(posedge clk) begin
        if (srst) begin
            trig_cnt <= 4'h0;
            trig_oe  <= 1'b0;
        end else if (conv_wr) begin
            trig_cnt <= 4'(TRIG_CYC + SYNC_GUARD);
            trig_oe  <= 1'b1;
        end else if (trig_cnt != 4'h0) begin
            trig_cnt <= trig_cnt - 4'h1;
            trig_oe  <= (trig_cnt - 4'h1) > 4'(SYNC_GUARD);
        end
    end

    wire ext_start = trig_fall & (trig_cnt == 4'h0);
    wire start_req = conv_wr | ext_start;

    ////////////////////////////////////////////////////////////////////////////////
    // conversion; a start while running is dropped, the converters ignore it too
    sac_conv_e                         cv_state;
    logic [CONV_W-1:0]                 cv_timer;
    logic                              cv_seen;
    logic [NUM_CH-1:0][SAMPLE_W-1:0]   result;
    wire cv_end = (cv_seen & ~any_busy) | (cv_timer == CONV_W'(CONV_CYC - 1));

    always_ff @(posedge clk) begin
        if (srst) begin
            cv_state   <= CV_IDLE;
            cv_timer   <= '0;
            cv_seen    <= 1'b0;
            conv_start <= 1'b0;
        end else begin
            conv_start <= 1'b0;
            unique case (cv_state)
                CV_IDLE: begin
                    if (start_req) begin
                        conv_start <= 1'b1;
                        cv_state   <= CV_RUN;
                        cv_timer   <= '0;
                        cv_seen    <= 1'b0;
                    end
                end
                CV_RUN: begin
                    cv_timer <= cv_timer + CONV_W'(1);
                    cv_seen  <= cv_seen | any_busy;
                    if (cv_end) cv_state <= CV_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            result <= '0;
        end else if (cv_state == CV_RUN && cv_end) begin
            for (int i = 0; i < NUM_CH; i++) begin
                result[i] <= SAMPLE_W'(raw_s[i]) << LSH;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // identification loader: streams bytes from eeprom after reset
    sac_load_e          ld_state;
    logic [7:0]         id_mem [ID_BYTES];
    logic [DIV_W-1:0]   div_cnt;
    logic [6:0]         shift;
    logic [2:0]         bit_cnt;
    logic [4:0]         byte_cnt;
    logic [WAIT_W-1:0]  id_wait;
    wire div_tick  = (div_cnt == DIV_W'(EE_DIV - 1));
    wire ee_rise   = div_tick & ~ee_sclk & (ld_state == LD_SHIFT);
    wire wait_over = (id_wait >= WAIT_W'(ID_WAIT_CYC));

    always_ff @(posedge clk) begin
        if (srst) begin
            ld_state <= LD_SHIFT;
            div_cnt  <= '0;
            ee_sclk  <= 1'b0;
            ee_cs    <= 1'b1;
            shift    <= '0;
            bit_cnt  <= '0;
            byte_cnt <= '0;
            id_wait  <= '0;
            id_ready <= 1'b0;
        end else begin
            div_cnt <= div_tick ? '0 : div_cnt + DIV_W'(1);
            if (!wait_over) id_wait <= id_wait + WAIT_W'(1);
            unique case (ld_state)
                LD_SHIFT: begin
                    if (div_tick) ee_sclk <= ~ee_sclk;
                    if (ee_rise) begin
                        shift   <= {shift[5:0], ee_s};
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == 3'h7) begin
                            byte_cnt <= byte_cnt + 5'h1;
                            if (byte_cnt == 5'(ID_BYTES - 1)) begin
                                ld_state <= LD_WAIT;
                                ee_cs    <= 1'b0;
                            end
                        end
                    end
                end
                LD_WAIT: begin
                    ee_sclk <= 1'b0;
                    if (wait_over) begin
                        ld_state <= LD_DONE;
                        id_ready <= 1'b1;
                    end
                end
                LD_DONE: id_ready <= 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (ee_rise && bit_cnt == 3'h7) id_mem[byte_cnt] <= {shift, ee_s};
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read data select
    wire [2:0]          ch_idx   = req.addr[4:2];
    wire [SAMPLE_W-1:0] ch_word  = result[ch_idx];
    wire [7:0]          data_byt = req.addr[1] ? ch_word[7:0] : ch_word[15:8];
    wire [4:0]          id_idx   = req.addr[5:1];
    wire                id_ok    = id_ready & req.addr[0] & (req.addr <= ADDR_ID_LAST);
    wire                busy_bit = any_busy | (cv_state == CV_RUN);

    always_comb begin
        rdata = 8'h00;
        if (req.id_sel) begin
            if (id_ok) rdata = id_mem[id_idx];
        end else if (data_rd) begin
            rdata = data_byt;
        end else if (stat_rd) begin
            rdata[STAT_BUSY_BIT] = busy_bit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    data_wait_a: assert property (@(posedge clk) disable iff (srst)
        (data_rd && !ws_done) |-> !ack ##1 (!data_rd || ack))
        else $error("sample read not acked after one wait state");
    zero_wait_a: assert property (@(posedge clk) disable iff (srst)
        ((req.io_sel || req.id_sel) && !data_rd) |-> ack)
        else $error("non-data access not acked at once");
    trig_pulse_a: assert property (@(posedge clk) disable iff (srst)
        (conv_wr && trig_cnt == 4'h0) |=> trig_oe [*5] ##1 !trig_oe)
        else $error("trigger pulse length wrong");
    cmd_start_a: assert property (@(posedge clk) disable iff (srst)
        (conv_wr && cv_state == CV_IDLE) |=> conv_start && cv_state == CV_RUN)
        else $error("convert write did not start conversion");
    ext_start_a: assert property (@(posedge clk) disable iff (srst)
        (ext_start && cv_state == CV_IDLE) |=> conv_start)
        else $error("external trigger did not start conversion");
    conv_bound_a: assert property (@(posedge clk) disable iff (srst)
        conv_start |-> ##[1:625] cv_state == CV_IDLE)
        else $error("conversion exceeded limit");
    hold_res_a: assert property (@(posedge clk) disable iff (srst)
        (cv_state == CV_IDLE) |=> $stable(result))
        else $error("results changed outside conversion end");
    id_gate_a: assert property (@(posedge clk) disable iff (srst)
        !wait_over |-> !id_ready)
        else $error("identification ready too early");
    stat_bit_a: assert property (@(posedge clk) disable iff (srst)
        stat_rd |-> rdata == {7'h00, busy_bit})
        else $error("status read wrong");
    low_zero_a: assert property (@(posedge clk) disable iff (srst)
        (cv_state == CV_RUN && cv_end) |=> (result[0] & LOW_MASK) == '0)
        else $error("low result bits not zero");

endmodule : sac_top

// ===== sac_pkg.sv
// Contract
// - identification data unavailable for 274 us after reset
// - sample data reads take exactly one wait state
// - all other accesses complete with zero waits
// - logic runs from the host bus clock; the code clocks it at CLK_PS (40 ns), not the 125 ns bus clock BUS_CLK_PS
// - conversion starts by command or trigger pin
// - one start samples all eight channels together
// - conversion finishes within 25 us of start
// - shared trigger driven by others starts conversion
// - result path handles 12-bit and 16-bit converters
// - correction constants loaded from EEPROM, host readable
// - any write to 0x21 starts a conversion; the code drops one that arrives while a conversion is running
// - convert command drives trigger low 1.5 bus cycles
// - status bit 0 shows any converter busy
// - 12-bit results left aligned, low nibble zero
package sac_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_PS       = 40000;
    localparam int BUS_CLK_PS   = 125000;
    localparam int TRIG_PS      = BUS_CLK_PS * 3 / 2;
    localparam int TRIG_CYC     = (TRIG_PS + CLK_PS - 1) / CLK_PS;
    localparam int SYNC_GUARD   = 3;
    localparam int CONV_US      = 25;
    localparam int CONV_CYC     = CONV_US * 1000000 / CLK_PS;
    localparam int CONV_W       = $clog2(CONV_CYC + 1);
    localparam int ID_WAIT_US   = 274;
    localparam int ID_WAIT_CYC  = (ID_WAIT_US * 1000000 + CLK_PS - 1) / CLK_PS;
    localparam int EE_DIV       = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // address map and fields
    localparam logic [7:0] ADDR_DATA_LAST = 8'h1F;
    localparam logic [7:0] ADDR_CONVERT   = 8'h21;
    localparam logic [7:0] ADDR_STATUS    = 8'h23;
    localparam logic [7:0] ADDR_ID_LAST   = 8'h37;
    localparam int         STAT_BUSY_BIT  = 0;
    localparam int         ID_BYTES       = 28;
    localparam int         NUM_CH         = 8;
    localparam int         SAMPLE_W       = 16;
    localparam int         RES_DEFAULT    = 16;

    ////////////////////////////////////////////////////////////////////////////////
    // types
    typedef struct packed {
        logic       io_sel;
        logic       id_sel;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sac_req_s;

    typedef enum logic [1:0] {
        CV_IDLE = 2'b01,
        CV_RUN  = 2'b10
    } sac_conv_e;

    typedef enum logic [2:0] {
        LD_SHIFT = 3'b001,
        LD_WAIT  = 3'b010,
        LD_DONE  = 3'b100
    } sac_load_e;

endpackage : sac_pkg

// ===== sac_host_model.sv
`timescale 1ns/100ps
module sac_host_model (
    // bus clock
    input  wire logic         clk,
    // host bus
    output sac_pkg::sac_req_s req,
    input  wire logic         ack,
    input  wire logic [7:0]   rdata
);
    import sac_pkg::*;

    initial req = '0;

    ////////////////////////////////////////////////////////////////////////////////
    // one access: held until ack is seen before an edge, dropped just after it
    // bounded wait so a dead ack shows up as a wait count of 8, not a hang
    task automatic xfer(input logic io, input logic id, input logic wr,
                        input logic [7:0] a, output logic [7:0] d, output int w);
        @(posedge clk);
        #1;
        req = '{io_sel: io, id_sel: id, wr: wr, addr: a, wdata: 8'h5A};
        w = 0;
        d = 8'h00;
        repeat (8) begin
            @(negedge clk);
            if (ack === 1'b1) break;
            w++;
        end
        d = rdata;
        @(posedge clk);
        #1;
        // released bus no longer shows the old address
        req = '{io_sel: 1'b0, id_sel: 1'b0, wr: ~wr, addr: ~a, wdata: 8'hA5};
    endtask : xfer
endmodule : sac_host_model

// ===== simultaneous_adc_control_tb.sv
`timescale 1ns/100ps
module simultaneous_adc_control_tb;
    import sac_pkg::*;
    localparam int RES = 12;
    logic                       clk = 1'b0;
    logic                       srst = 1'b1;
    logic                       ext_n = 1'b1;
    sac_req_s                   req;
    logic [7:0]                 rdata, ee_val;
    logic                       ack, trig_n_out, trig_oe, conv_start, ee_cs, ee_sclk;
    logic                       id_ready, trig_n_in, ee_do;
    logic [NUM_CH-1:0]          adc_busy = '0;
    logic [NUM_CH-1:0][RES-1:0] adc_raw;
    int                         fails = 0, n_compared = 0, nconv = 0, busy_cnt = 0, ee_bit = 0;
    int                         cyc = 0;

    always #20 clk = ~clk;
    // edges since reset release, to time the identification gate
    always @(posedge clk) if (!srst) cyc <= cyc + 1;
    // pulled-up shared line: low when any party drives it
    assign trig_n_in = ext_n & ~(trig_oe & ~trig_n_out);
    ////////////////////////////////////////////////////////////////////////////////
    // eeprom: byte k is 0xc0+k, next bit set up on the falling clock
    assign ee_val = 8'hC0 + 8'(ee_bit / 8);
    assign ee_do = ee_cs ? ee_val[7 - (ee_bit % 8)] : clk;
    always @(negedge ee_sclk) if (ee_cs && !srst) ee_bit <= ee_bit + 1;
    ////////////////////////////////////////////////////////////////////////////////
    // converters: garbage on the outputs while busy, fresh value after
    function automatic logic [RES-1:0] cval(int ch, int n);
        return {4'(n), 4'(ch), 4'hA};
    endfunction : cval
    always @(posedge clk) begin
        if (conv_start === 1'b1) begin
            adc_busy <= '1;
            busy_cnt <= 40;
        end else if (busy_cnt > 0) begin
            busy_cnt <= busy_cnt - 1;
            if (busy_cnt == 1) begin
                adc_busy <= '0;
                nconv <= nconv + 1;
            end
        end
    end
    always_comb for (int c = 0; c < NUM_CH; c++)
        adc_raw[c] = adc_busy[c] ? ~cval(c, nconv) : cval(c, nconv);

    sac_top #(.RES_BITS(RES), .ID_WAIT_CYC(ID_WAIT_CYC)) sac_top_inst (
        .clk(clk), .srst(srst), .req(req), .rdata(rdata), .ack(ack),
        .trig_n_in(trig_n_in), .trig_n_out(trig_n_out), .trig_oe(trig_oe),
        .conv_start(conv_start), .adc_busy(adc_busy), .adc_raw(adc_raw),
        .ee_cs(ee_cs), .ee_sclk(ee_sclk), .ee_do(ee_do), .id_ready(id_ready));
    sac_host_model sac_host_model_inst (.clk(clk), .req(req), .ack(ack), .rdata(rdata));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic acc(input logic io, id, wr, input logic [7:0] a, exp, input int expw,
                       input string what);
        logic [7:0] d;
        int         w;
        sac_host_model_inst.xfer(io, id, wr, a, d, w);
        if (!wr) check({what, " data"}, 16'(d), 16'(exp));
        check({what, " waits"}, 16'(w), 16'(expw));
    endtask : acc
    task automatic poll(input string what);
        logic [7:0] d;
        int         w, i;
        sac_host_model_inst.xfer(1'b1, 1'b0, 1'b0, ADDR_STATUS, d, w);
        check({what, " busy"}, 16'(d), 16'h0001);
        for (i = 0; i < 200 && d[STAT_BUSY_BIT] !== 1'b0; i++)
            sac_host_model_inst.xfer(1'b1, 1'b0, 1'b0, ADDR_STATUS, d, w);
        check({what, " idle"}, 16'(d), 16'h0000);
    endtask : poll
    task automatic results(input int n);
        logic [RES-1:0] v;
        for (int c = 0; c < NUM_CH; c++) begin
            v = cval(c, n);
            acc(1'b1, 1'b0, 1'b0, 8'(1 + 4 * c), v[11:4], 1, "sample high");
            acc(1'b1, 1'b0, 1'b0, 8'(3 + 4 * c), {v[3:0], 4'h0}, 1, "sample low");
        end
    endtask : results
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_id;
        acc(1'b0, 1'b1, 1'b0, 8'h01, 8'h00, 0, "early id");
        check("early ready", 16'(id_ready), 16'h0000);
        for (int i = 0; i < 8000 && id_ready !== 1'b1; i++) @(negedge clk);
        check("id ready", 16'(id_ready), 16'h0001);
        // ready is registered one edge after the full wait has been counted
        check("id ready time", 16'(cyc), 16'(ID_WAIT_CYC + 1));
        acc(1'b0, 1'b1, 1'b0, 8'h01, 8'hC0, 0, "id first");
        acc(1'b0, 1'b1, 1'b0, ADDR_ID_LAST, 8'hDB, 0, "id last");
        acc(1'b0, 1'b1, 1'b0, 8'h02, 8'h00, 0, "id even");
        $display("test id done");
    endtask : t_id
    task automatic t_ext;
        int n;
        @(posedge clk);
        #1;
        ext_n = 1'b0;
        for (n = 0; n < 10; n++) begin
            @(negedge clk);
            if (conv_start === 1'b1) break;
        end
        check("ext start delay", 16'(n), 16'd3);
        @(posedge clk);
        #1;
        ext_n = 1'b1;
        poll("ext");
        results(1);
        $display("test ext_trigger done");
    endtask : t_ext
    task automatic t_cmd;
        int oe, st;
        oe = 0;
        st = 0;
        acc(1'b1, 1'b0, 1'b1, ADDR_CONVERT, 8'h00, 0, "convert");
        repeat (10) begin
            @(negedge clk);
            oe += (trig_oe === 1'b1 && trig_n_out === 1'b0);
            st += (conv_start === 1'b1);
        end
        check("trigger drive", 16'(oe), 16'd5);
        check("start pulses", 16'(st), 16'd1);
        // early read still shows the last completed conversion
        acc(1'b1, 1'b0, 1'b0, 8'h01, 8'h10, 1, "held result");
        poll("cmd");
        results(2);
        $display("test command done");
    endtask : t_cmd
    task automatic t_misc;
        int st;
        st = 0;
        acc(1'b1, 1'b0, 1'b1, ADDR_STATUS, 8'h00, 0, "status write");
        acc(1'b1, 1'b0, 1'b1, 8'h30, 8'h00, 0, "stray write");
        repeat (10) begin
            @(negedge clk);
            st += (conv_start === 1'b1);
        end
        check("no start", 16'(st), 16'd0);
        acc(1'b1, 1'b0, 1'b0, ADDR_CONVERT, 8'h00, 0, "convert read");
        acc(1'b1, 1'b0, 1'b0, 8'h30, 8'h00, 0, "unmapped");
        acc(1'b1, 1'b0, 1'b0, ADDR_STATUS, 8'h00, 0, "status idle");
        $display("test misc done");
    endtask : t_misc
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #(40 * 12000);
        fails++;
        $display("Error watchdog expected finish seen timeout");
        stop_test();
    end
    initial begin
        repeat (3) @(posedge clk);
        #1;
        srst = 1'b0;
        repeat (3) @(posedge clk);
        t_id();
        t_ext();
        t_cmd();
        t_misc();
        stop_test();
    end
endmodule : simultaneous_adc_control_tb
